// file: design/spi_cfg_pkg.sv
// Shared constants and types for the serial configuration port and its controller
package spi_cfg_pkg;
    // Device register space
    localparam int ADDR_W = 7;
    localparam int REG_NUM = 128;
    localparam logic [6:0] CFG_ADDR = 7'h00;
    localparam int CFG_BIDIR_BIT = 7;
    localparam int CFG_LSB_BIT = 6;
    localparam logic [7:0] CFG_RESET = 8'h00;
    localparam int NCO_FIRST = 'h30;
    localparam int NCO_BYTES = 6;
    localparam int NCO_W = NCO_BYTES * 8;
    localparam logic [6:0] UPDATE_ADDR = 7'h36;
    localparam int UPDATE_BIT = 0;

    // Serial clock timing, generated by the controller
    localparam int CLK_NS = 25;
    localparam int SCLK_HALF_NS = 100;
    localparam int SCLK_HALF_CYC = (SCLK_HALF_NS + CLK_NS - 1) / CLK_NS;

    // Controller registers on AXI4-Lite
    localparam int AXI_AW = 8;
    localparam logic [7:0] CTRL_OFF = 8'h00;
    localparam logic [7:0] TXD_OFF = 8'h04;
    localparam logic [7:0] RXD_OFF = 8'h08;
    localparam logic [7:0] STAT_OFF = 8'h0C;
    localparam logic [7:0] MODE_OFF = 8'h10;
    localparam int CTRL_START = 0;
    localparam int CTRL_READ = 1;
    localparam int CTRL_ADDR_LSB = 8;
    localparam int CTRL_CNT_LSB = 16;
    localparam int STAT_BUSY = 0;
    localparam int MODE_BIDIR = 0;
    localparam int MODE_LSB = 1;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [2:0] {
        PH_INSTR = 3'b001,
        PH_WRITE = 3'b010,
        PH_READ = 3'b100
    } dev_phase_e;

    typedef enum logic [3:0] {
        HS_IDLE = 4'b0001,
        HS_LEAD = 4'b0010,
        HS_SHIFT = 4'b0100,
        HS_TRAIL = 4'b1000
    } host_st_e;
endpackage

// file: design/spi_if.sv
// Four-wire serial link between the controller and the configuration port
`timescale 1ns/10ps
`default_nettype none
interface spi_if;
    logic sclk;
    logic cs_n;
    logic host_sdio_o;
    logic host_sdio_oe;
    logic dev_sdio_o;
    logic dev_sdio_oe;
    logic dev_sdo_o;
    logic dev_sdo_oe;
    wire sdio_line;
    wire sdo_line;

    // Undriven lines rest high as with a pull-up
    assign sdio_line = host_sdio_oe ? host_sdio_o : (dev_sdio_oe ? dev_sdio_o : 1'b1);
    assign sdo_line = dev_sdo_oe ? dev_sdo_o : 1'b1;

    modport host (
        output sclk,
        output cs_n,
        output host_sdio_o,
        output host_sdio_oe,
        input sdio_line,
        input sdo_line
    );

    modport device (
        input sclk,
        input cs_n,
        input sdio_line,
        output dev_sdio_o,
        output dev_sdio_oe,
        output dev_sdo_o,
        output dev_sdo_oe
    );
endinterface
`default_nettype wire

// file: design/cfg_port_device.sv
// Serial configuration port of the converter, device end of the link
// Behaviour
// RL1: First eight rising edges shift the instruction
// RL2: Chip select high restarts the instruction phase
// RL3: Bytes apply at last bit; oscillator words wait
// RL4: Instruction top bit one reads, zero writes
// RL5: Lower seven instruction bits give start address
// RL6: Input bits sampled on serial clock rise
// RL7: Read bits change on serial clock fall
// RL8: Chip select high floats both data pins
// RL9: Host keeps chip select low whole transfer
// RL10: Config bit seven picks bidirectional data pin
// RL11: Bidirectional mode never drives the output pin
// RL12: Config bit six picks LSB-first ordering
// RL13: MSB-first sends high bit first, address decrements
// RL14: LSB-first sends low bit first, address increments
// RL15: MSB-first host starts at most significant byte
// RL16: LSB-first host starts at least significant byte
// RL17: Read data leaves on pin of mode
`timescale 1ns/10ps
`default_nettype none
module cfg_port_device (
    input wire logic aclk,
    input wire logic aresetn,
    spi_if.device link,
    output logic cfg_bidir,
    output logic cfg_lsb_first,
    output logic wr_strobe,
    output logic [6:0] wr_addr,
    output logic [7:0] wr_data,
    output logic [spi_cfg_pkg::NCO_W-1:0] nco_word
);

    typedef struct packed {
        spi_cfg_pkg::dev_phase_e phase;
        logic sclk_q;
        logic [2:0] bit_cnt;
        logic [7:0] shift;
        logic [7:0] tx;
        logic [6:0] addr;
        logic sdio_o;
        logic sdio_oe;
        logic sdo_o;
        logic sdo_oe;
        logic wr_strobe;
        logic [6:0] wr_addr;
        logic [7:0] wr_data;
        logic [spi_cfg_pkg::NCO_W-1:0] nco;
        logic [spi_cfg_pkg::REG_NUM-1:0][7:0] regs;
    } dev_state_s;

    dev_state_s r;
    dev_state_s n;
    logic rise;
    logic fall;
    logic lsb;
    logic bidir;
    logic din;
    logic dout;
    logic [7:0] shifted;
    logic [6:0] nxt_addr;

    // Address generator walks down in MSB-first, up in LSB-first
    function automatic logic [6:0] step_addr(input logic [6:0] a, input logic lsb_mode);
        logic [6:0] res;
        if (lsb_mode) begin
            res = 7'(a + 7'h01);
        end else begin
            res = 7'(a - 7'h01);
        end
        return res;
    endfunction

    always_comb begin
        n = r;
        n.wr_strobe = 1'b0;
        n.sclk_q = link.sclk;
        rise = link.sclk & ~r.sclk_q;
        fall = ~link.sclk & r.sclk_q;
        lsb = r.regs[spi_cfg_pkg::CFG_ADDR][spi_cfg_pkg::CFG_LSB_BIT]; // see RL12
        bidir = r.regs[spi_cfg_pkg::CFG_ADDR][spi_cfg_pkg::CFG_BIDIR_BIT]; // see RL10
        din = link.sdio_line;
        dout = lsb ? r.tx[0] : r.tx[7];
        shifted = lsb ? {din, r.shift[7:1]} : {r.shift[6:0], din}; // see RL13 see RL14
        nxt_addr = step_addr(r.addr, lsb);
        if (link.cs_n) begin
            // Idle select restarts the frame and floats the data pins
            n.phase = spi_cfg_pkg::PH_INSTR; // see RL2
            n.bit_cnt = 3'h0;
            n.sdio_oe = 1'b0; // see RL8
            n.sdo_oe = 1'b0;
        end else begin
            if (rise) begin
                // Every input bit is taken on the rising serial edge
                n.shift = shifted; // see RL6
                n.bit_cnt = 3'(r.bit_cnt + 3'h1);
                if (r.bit_cnt == 3'h7) begin
                    case (r.phase)
                        spi_cfg_pkg::PH_INSTR: begin
                            // Eighth rise closes the instruction byte
                            n.addr = shifted[6:0]; // see RL1 see RL5
                            n.tx = r.regs[shifted[6:0]];
                            if (shifted[7]) begin
                                n.phase = spi_cfg_pkg::PH_READ; // see RL4
                            end else begin
                                n.phase = spi_cfg_pkg::PH_WRITE;
                            end
                        end
                        spi_cfg_pkg::PH_WRITE: begin
                            // Byte lands the moment its last bit arrives
                            n.regs[r.addr] = shifted; // see RL3
                            n.wr_strobe = 1'b1;
                            n.wr_addr = r.addr;
                            n.wr_data = shifted;
                            if (r.addr == spi_cfg_pkg::UPDATE_ADDR &&
                                shifted[spi_cfg_pkg::UPDATE_BIT]) begin
                                // Oscillator words move to the datapath only here
                                for (int i = 0; i < spi_cfg_pkg::NCO_BYTES; i++) begin
                                    n.nco[i*8 +: 8] = r.regs[7'(spi_cfg_pkg::NCO_FIRST + i)];
                                end
                                n.regs[r.addr][spi_cfg_pkg::UPDATE_BIT] = 1'b0; // see RL3
                            end
                            n.addr = nxt_addr; // see RL13 see RL14
                        end
                        spi_cfg_pkg::PH_READ: begin
                            n.addr = nxt_addr; // see RL13 see RL14
                            n.tx = r.regs[nxt_addr];
                        end
                        default: begin
                            n.phase = spi_cfg_pkg::PH_INSTR;
                        end
                    endcase
                end
            end
            if (fall && r.phase == spi_cfg_pkg::PH_READ) begin
                // Read bits change on the falling edge, so the host samples on the rise
                n.tx = lsb ? {1'b0, r.tx[7:1]} : {r.tx[6:0], 1'b0}; // see RL7
                if (bidir) begin
                    n.sdio_o = dout; // see RL17
                    n.sdio_oe = 1'b1;
                    n.sdo_oe = 1'b0; // see RL11
                end else begin
                    n.sdo_o = dout; // see RL17
                    n.sdo_oe = 1'b1;
                    n.sdio_oe = 1'b0;
                end
            end
            if (r.phase != spi_cfg_pkg::PH_READ) begin
                n.sdio_oe = 1'b0;
                n.sdo_oe = 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            r <= '0;
            r.phase <= spi_cfg_pkg::PH_INSTR;
            r.sclk_q <= 1'b0;
            r.regs[spi_cfg_pkg::CFG_ADDR] <= spi_cfg_pkg::CFG_RESET; // see RL10 see RL12
        end else begin
            r <= n;
        end
    end

    // Pins and user outputs come straight from the state register
    assign link.dev_sdio_o = r.sdio_o;
    assign link.dev_sdio_oe = r.sdio_oe;
    assign link.dev_sdo_o = r.sdo_o;
    assign link.dev_sdo_oe = r.sdo_oe;
    assign cfg_bidir = r.regs[spi_cfg_pkg::CFG_ADDR][spi_cfg_pkg::CFG_BIDIR_BIT];
    assign cfg_lsb_first = r.regs[spi_cfg_pkg::CFG_ADDR][spi_cfg_pkg::CFG_LSB_BIT];
    assign wr_strobe = r.wr_strobe;
    assign wr_addr = r.wr_addr;
    assign wr_data = r.wr_data;
    assign nco_word = r.nco;

endmodule
`default_nettype wire

// file: design/cfg_port_host.sv
// Serial controller that masters the configuration port, driven over AXI4-Lite
//
// Chosen here: the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
`default_nettype none
module cfg_port_host #(
    parameter int HALF = spi_cfg_pkg::SCLK_HALF_CYC
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [spi_cfg_pkg::AXI_AW-1:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [spi_cfg_pkg::AXI_AW-1:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    spi_if.host link
);

    typedef struct packed {
        spi_cfg_pkg::host_st_e st;
        logic [7:0] div;
        logic sclk;
        logic cs_n;
        logic sdio_o;
        logic sdio_oe;
        logic [2:0] byte_idx;
        logic [2:0] bit_idx;
        logic rd;
        logic [6:0] addr;
        logic [1:0] cnt;
        logic bidir;
        logic lsb;
        logic [31:0] txd;
        logic [31:0] rxd;
        logic awready;
        logic wready;
        logic aw_have;
        logic w_have;
        logic [spi_cfg_pkg::AXI_AW-1:0] awaddr_q;
        logic [31:0] wdata_q;
        logic [3:0] wstrb_q;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } host_state_s;

    host_state_s r;
    host_state_s n;
    logic start;
    logic last;
    logic [31:0] ctrl_word;
    logic [31:0] mode_word;
    logic [31:0] wv;
    logic [7:0] instr;
    logic [2:0] nbyte;
    logic [2:0] nbit;
    logic [2:0] pos;
    logic [1:0] lane;

    function automatic logic [2:0] bit_pos(input logic [2:0] k, input logic lsb_mode);
        return lsb_mode ? k : 3'(3'h7 - k);
    endfunction

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] strb);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                res[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return res;
    endfunction

    always_comb begin
        n = r;
        start = 1'b0;
        wv = '0;
        ctrl_word = '0;
        ctrl_word[spi_cfg_pkg::CTRL_READ] = r.rd;
        ctrl_word[spi_cfg_pkg::CTRL_ADDR_LSB +: 7] = r.addr;
        ctrl_word[spi_cfg_pkg::CTRL_CNT_LSB +: 2] = r.cnt;
        mode_word = '0;
        mode_word[spi_cfg_pkg::MODE_BIDIR] = r.bidir;
        mode_word[spi_cfg_pkg::MODE_LSB] = r.lsb;
        instr = {r.rd, r.addr}; // see RL4 see RL5
        last = (r.byte_idx == 3'({1'b0, r.cnt} + 3'h1)) && (r.bit_idx == 3'h7);
        // AXI write: address and data taken in either order, response after both
        if (awvalid && r.awready) begin
            n.aw_have = 1'b1;
            n.awaddr_q = awaddr;
        end
        if (wvalid && r.wready) begin
            n.w_have = 1'b1;
            n.wdata_q = wdata;
            n.wstrb_q = wstrb;
        end
        if (r.bvalid && bready) begin
            n.bvalid = 1'b0;
        end
        if (r.aw_have && r.w_have && !r.bvalid) begin
            n.aw_have = 1'b0;
            n.w_have = 1'b0;
            n.bvalid = 1'b1;
            n.bresp = spi_cfg_pkg::RESP_OKAY;
            // Setup is frozen while a frame runs; such writes are dropped
            case (r.awaddr_q)
                spi_cfg_pkg::CTRL_OFF: begin
                    if (r.st == spi_cfg_pkg::HS_IDLE) begin
                        wv = merge(ctrl_word, r.wdata_q, r.wstrb_q);
                        n.rd = wv[spi_cfg_pkg::CTRL_READ];
                        n.addr = wv[spi_cfg_pkg::CTRL_ADDR_LSB +: 7];
                        n.cnt = wv[spi_cfg_pkg::CTRL_CNT_LSB +: 2];
                        start = wv[spi_cfg_pkg::CTRL_START] & r.wstrb_q[0];
                    end
                end
                spi_cfg_pkg::TXD_OFF: begin
                    if (r.st == spi_cfg_pkg::HS_IDLE) begin
                        n.txd = merge(r.txd, r.wdata_q, r.wstrb_q);
                    end
                end
                spi_cfg_pkg::MODE_OFF: begin
                    if (r.st == spi_cfg_pkg::HS_IDLE) begin
                        wv = merge(mode_word, r.wdata_q, r.wstrb_q);
                        n.bidir = wv[spi_cfg_pkg::MODE_BIDIR];
                        n.lsb = wv[spi_cfg_pkg::MODE_LSB];
                    end
                end
                spi_cfg_pkg::RXD_OFF, spi_cfg_pkg::STAT_OFF: begin
                end
                default: begin
                    n.bresp = spi_cfg_pkg::RESP_SLVERR;
                end
            endcase
        end
        n.awready = !n.aw_have && !n.bvalid;
        n.wready = !n.w_have && !n.bvalid;
        // AXI read
        if (r.rvalid && rready) begin
            n.rvalid = 1'b0;
        end
        if (arvalid && r.arready) begin
            n.rvalid = 1'b1;
            n.rresp = spi_cfg_pkg::RESP_OKAY;
            case (araddr)
                spi_cfg_pkg::CTRL_OFF: n.rdata = ctrl_word;
                spi_cfg_pkg::TXD_OFF: n.rdata = r.txd;
                spi_cfg_pkg::RXD_OFF: n.rdata = r.rxd;
                spi_cfg_pkg::STAT_OFF: n.rdata = {31'h0, r.st != spi_cfg_pkg::HS_IDLE};
                spi_cfg_pkg::MODE_OFF: n.rdata = mode_word;
                default: begin
                    n.rdata = '0;
                    n.rresp = spi_cfg_pkg::RESP_SLVERR;
                end
            endcase
        end
        n.arready = !n.rvalid;
        // Serial engine: bit to drive for the position after any advance
        nbyte = r.byte_idx;
        nbit = r.bit_idx;
        if (r.st == spi_cfg_pkg::HS_SHIFT && r.sclk && !last) begin
            nbit = 3'(r.bit_idx + 3'h1);
            if (r.bit_idx == 3'h7) begin
                nbyte = 3'(r.byte_idx + 3'h1);
            end
        end
        pos = bit_pos(nbit, r.lsb); // see RL13 see RL14
        lane = 2'(nbyte - 3'h1);
        case (r.st)
            spi_cfg_pkg::HS_IDLE: begin
                if (start) begin
                    n.st = spi_cfg_pkg::HS_LEAD;
                    n.cs_n = 1'b0; // see RL9
                    n.div = '0;
                    n.byte_idx = 3'h0;
                    n.bit_idx = 3'h0;
                end
            end
            spi_cfg_pkg::HS_LEAD: begin
                n.sdio_o = instr[pos]; // see RL1
                n.sdio_oe = 1'b1;
                n.div = 8'(r.div + 8'h01);
                if (r.div == 8'(HALF - 1)) begin
                    n.div = '0;
                    n.st = spi_cfg_pkg::HS_SHIFT;
                end
            end
            spi_cfg_pkg::HS_SHIFT: begin
                n.div = 8'(r.div + 8'h01);
                if (r.div == 8'(HALF - 1)) begin
                    n.div = '0;
                    if (!r.sclk) begin
                        n.sclk = 1'b1; // see RL6
                        if (r.rd && r.byte_idx != 3'h0) begin
                            n.rxd[{2'(r.byte_idx - 3'h1), bit_pos(r.bit_idx, r.lsb)}] =
                                r.bidir ? link.sdio_line : link.sdo_line; // see RL17
                        end
                    end else begin
                        n.sclk = 1'b0;
                        if (last) begin
                            n.st = spi_cfg_pkg::HS_TRAIL;
                            n.sdio_oe = 1'b0;
                        end else begin
                            // Bytes go in register order, lowest lane first
                            n.byte_idx = nbyte; // see RL15 see RL16
                            n.bit_idx = nbit;
                            n.sdio_o = (nbyte == 3'h0) ? instr[pos] : r.txd[{lane, pos}];
                            // Line is released before the device turns it round
                            n.sdio_oe = !(r.rd && nbyte != 3'h0);
                        end
                    end
                end
            end
            spi_cfg_pkg::HS_TRAIL: begin
                n.div = 8'(r.div + 8'h01);
                if (r.div == 8'(HALF - 1)) begin
                    n.div = '0;
                    n.cs_n = 1'b1; // see RL9
                    n.st = spi_cfg_pkg::HS_IDLE;
                end
            end
            default: begin
                n.st = spi_cfg_pkg::HS_IDLE;
                n.cs_n = 1'b1;
                n.sdio_oe = 1'b0;
            end
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            r <= '0;
            r.st <= spi_cfg_pkg::HS_IDLE;
            r.cs_n <= 1'b1;
        end else begin
            r <= n;
        end
    end

    assign awready = r.awready;
    assign wready = r.wready;
    assign bresp = r.bresp;
    assign bvalid = r.bvalid;
    assign arready = r.arready;
    assign rdata = r.rdata;
    assign rresp = r.rresp;
    assign rvalid = r.rvalid;
    assign link.sclk = r.sclk;
    assign link.cs_n = r.cs_n;
    assign link.host_sdio_o = r.sdio_o;
    assign link.host_sdio_oe = r.sdio_oe;

endmodule
`default_nettype wire

// file: verif/dac_config_serial_port_properties.sv
// Timing checks on the serial link between controller and port
`timescale 1ns/10ps
`default_nettype none
module dac_config_serial_port_properties (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic host_sdio_o,
    input wire logic host_sdio_oe,
    input wire logic dev_sdio_o,
    input wire logic dev_sdio_oe,
    input wire logic dev_sdo_o,
    input wire logic dev_sdo_oe
);
    logic prev_sclk;
    logic [7:0] rise_cnt;
    // Rising edges of the serial clock since chip select fell
    always_ff @(posedge aclk) begin
        if (!aresetn || cs_n) begin
            prev_sclk <= 1'b0;
            rise_cnt <= 8'h00;
        end else begin
            prev_sclk <= sclk;
            if (sclk && !prev_sclk) begin
                rise_cnt <= rise_cnt + 8'h01;
            end
        end
    end
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    instr_phase_quiet_a: assert property (
        !cs_n && rise_cnt < 8'h08 |-> !dev_sdio_oe && !dev_sdo_oe)
        else $error("device drove a pin in the instruction byte");
    cs_float_a: assert property (cs_n && $past(cs_n) |-> !dev_sdio_oe && !dev_sdo_oe)
        else $error("device pin driven while deselected");
    one_out_pin_a: assert property (!(dev_sdio_oe && dev_sdo_oe))
        else $error("device drove both data pins");
    no_fight_a: assert property (host_sdio_oe |-> !dev_sdio_oe)
        else $error("both ends drive the shared pin");
    read_pin_free_a: assert property (dev_sdo_oe |-> !host_sdio_oe)
        else $error("out pin driven outside a read");
    sdo_on_fall_a: assert property (
        dev_sdo_oe && $past(dev_sdo_oe) && $changed(dev_sdo_o) |-> !sclk)
        else $error("out pin changed while clock high");
    sdio_on_fall_a: assert property (
        dev_sdio_oe && $past(dev_sdio_oe) && $changed(dev_sdio_o) |-> !sclk)
        else $error("shared pin changed while clock high");
    sample_stable_a: assert property (sclk && host_sdio_oe |-> $stable(host_sdio_o))
        else $error("host data moved while clock high");
    // Lead phase plus the first low half period keep the clock low for two halves
    lead_time_a: assert property ($fell(cs_n) |-> !sclk [*8] ##1 sclk)
        else $error("wrong lead before first clock");
    sclk_high_a: assert property ($rose(sclk) |-> sclk [*4] ##1 !sclk)
        else $error("wrong clock high time");
    sclk_gated_a: assert property (cs_n |-> !sclk)
        else $error("clock ran while deselected");
endmodule
`default_nettype wire

// file: verif/dac_config_serial_port_bench.sv
// Random and corner-case bench for controller and port joined by the link
`timescale 1ns/10ps
`default_nettype none
module dac_config_serial_port_bench;
    logic aclk = 1'b0, aresetn = 1'b0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [31:0] wdata = 32'h0;
    logic [3:0] wstrb = 4'h0;
    logic awready, wready, bvalid, arready, rvalid, cfg_bidir, cfg_lsb_first, wr_strobe;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic [6:0] wr_addr;
    logic [7:0] wr_data;
    logic [47:0] nco_word;
    int n_fail = 0, checked = 0, seed = 71317;
    logic [7:0] mem [128];
    logic [14:0] wr_q [$];
    initial forever #12.5 aclk = ~aclk;
    spi_if spi_if_i ();
    cfg_port_host #(.HALF(4)) cfg_port_host_i (.aclk, .aresetn, .awaddr, .awvalid, .awready,
        .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready,
        .rdata, .rresp, .rvalid, .rready, .link(spi_if_i.host));
    cfg_port_device cfg_port_device_i (.aclk, .aresetn, .link(spi_if_i.device), .cfg_bidir,
        .cfg_lsb_first, .wr_strobe, .wr_addr, .wr_data, .nco_word);
    dac_config_serial_port_properties props_i (.aclk, .aresetn, .sclk(spi_if_i.sclk),
        .cs_n(spi_if_i.cs_n), .host_sdio_o(spi_if_i.host_sdio_o),
        .host_sdio_oe(spi_if_i.host_sdio_oe), .dev_sdio_o(spi_if_i.dev_sdio_o),
        .dev_sdio_oe(spi_if_i.dev_sdio_oe), .dev_sdo_o(spi_if_i.dev_sdo_o),
        .dev_sdo_oe(spi_if_i.dev_sdo_oe));
    always @(posedge aclk) if (wr_strobe === 1'b1) wr_q.push_back({wr_addr, wr_data});
    task automatic tally_and_finish;
        if (n_fail == 0 && checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    function automatic logic [6:0] exp_addr(input logic [6:0] a, input int k, input logic lsb);
        return lsb ? 7'(a + 7'(k)) : 7'(a - 7'(k));
    endfunction
    initial begin
        #1500000;
        n_fail++;
        tally_and_finish();
    end
    task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
        checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        @(posedge aclk);
        {awaddr, wdata, wstrb} <= {a, d, 4'hF};
        {awvalid, wvalid, bready} <= 3'b111;
        do begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        r = bresp;
        bready <= 1'b0;
    endtask
    task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge aclk);
        araddr <= a;
        {arvalid, rready} <= 2'b11;
        do begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        {r, d} = {rresp, rdata};
        rready <= 1'b0;
    endtask
    // One serial transfer of cnt bytes, checked against the shadow copy
    task automatic frame(input logic rd, input logic [6:0] a, input int cnt,
                         input logic [31:0] tx, input logic lsb);
        logic [1:0] r;
        logic [31:0] d;
        logic [6:0] ad;
        if (!rd) axi_wr(spi_cfg_pkg::TXD_OFF, tx, r);
        axi_wr(spi_cfg_pkg::CTRL_OFF, {14'h0, 2'(cnt - 1), 1'b0, a, 6'h0, rd, 1'b1}, r);
        do axi_rd(spi_cfg_pkg::STAT_OFF, d, r); while (d[spi_cfg_pkg::STAT_BUSY] !== 1'b0);
        if (rd) axi_rd(spi_cfg_pkg::RXD_OFF, d, r);
        for (int k = 0; k < cnt; k++) begin
            ad = exp_addr(a, k, lsb);
            if (rd) begin
                check("read byte", d[8*k+:8], mem[ad]);
            end else begin
                mem[ad] = tx[8*k+:8];
                check("written byte", wr_q.pop_front(), {ad, tx[8*k+:8]});
            end
        end
        check("extra writes", wr_q.size(), 0);
    endtask
    initial begin
        logic [31:0] d;
        logic [1:0] r;
        logic [1:0] m;
        logic [6:0] a;
        int cnt;
        foreach (mem[i]) mem[i] = 8'h00;
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        check("config pins", {cfg_bidir, cfg_lsb_first}, 2'b00);
        axi_rd(8'h20, d, r);
        check("unmapped read", {r, d}, {spi_cfg_pkg::RESP_SLVERR, 32'h0});
        axi_wr(8'h20, 32'hFFFF_FFFF, r);
        check("unmapped write", r, spi_cfg_pkg::RESP_SLVERR);
        // Modes as {bidir, lsb}: MSB uni, LSB uni, LSB bidir, MSB bidir
        for (int i = 0; i < 4; i++) begin
            m = (i == 0) ? 2'b00 : (i == 1) ? 2'b01 : (i == 2) ? 2'b11 : 2'b10;
            frame(1'b0, 7'h00, 1, {24'h0, m, 6'h0}, cfg_lsb_first);
            axi_wr(spi_cfg_pkg::MODE_OFF, {30'h0, m[0], m[1]}, r);
            check("config pins", {cfg_bidir, cfg_lsb_first}, m);
            axi_rd(spi_cfg_pkg::MODE_OFF, d, r);
            check("mode readback", {r, d}, {spi_cfg_pkg::RESP_OKAY, 30'h0, m[0], m[1]});
            repeat (4) begin
                a = (m[0] ? 7'h40 : 7'h43) + 7'($unsigned($random(seed)) % 61);
                cnt = 1 + ($random(seed) & 3);
                d = $random(seed);
                frame(1'b0, a, cnt, d, m[0]);
                frame(1'b1, a, cnt, d, m[0]);
            end
        end
        // Oscillator bytes wait for the update flag
        frame(1'b0, 7'h35, 4, $random(seed), 1'b0);
        frame(1'b0, 7'h31, 2, $random(seed), 1'b0);
        check("nco before update", nco_word, 48'h0);
        frame(1'b0, spi_cfg_pkg::UPDATE_ADDR, 1, 32'h1, 1'b0);
        check("nco after update", nco_word,
              {mem[7'h35], mem[7'h34], mem[7'h33], mem[7'h32], mem[7'h31], mem[7'h30]});
        tally_and_finish();
    end
endmodule
`default_nettype wire
